//--- core/iwp_pkg.sv
// Shared constants for the indirect word push executer
package iwp_pkg;

	// Instruction encoding
	localparam logic [7:0] FIRST_BYTE = 8'h27;
	localparam int IDX_MSB = 6;
	localparam int IDX_LSB = 1;
	localparam int FORM_BIT = 7;
	localparam int TAIL_BIT = 0;
	localparam int NUM_PTR_REGS = 64;

	// Data widths: bytes carry a ninth bit
	localparam int ADDR_W = 16;
	localparam int BYTE_W = 9;
	localparam int NINTH_BIT = 8;
	localparam int PSW_COPY_BIT = 1;

	// Pointer registers sit in data memory, two bytes each from address 0
	localparam logic [15:0] PTR_BASE = 16'h0000;

	// Instruction length in bytes and length in instruction cycles
	localparam logic [15:0] INSTR_BYTES = 16'h0002;
	localparam logic [1:0] INSTR_CYCLES = 2'h3;

	// Instruction cycle timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int INSTR_CYCLE_NS = 200;
	localparam int CLKS_PER_CYCLE = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int DIV_W = 3;

	// Reset values
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic [15:0] PC_RESET = 16'h0000;

	// Sequencer states
	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_PTR_LO = 10'h002,
		ST_PTR_HI = 10'h004,
		ST_PTR_GET = 10'h008,
		ST_SRC_LO = 10'h010,
		ST_SRC_HI = 10'h020,
		ST_SRC_GET = 10'h040,
		ST_WR_LO = 10'h080,
		ST_WR_HI = 10'h100,
		ST_FINISH = 10'h200
	} iwp_state_t;

endpackage

//--- core/iwp_decode.sv
// Second-byte decoder for the two indirect word push forms
`timescale 1ns/1ps
module iwp_decode (
	input wire logic [7:0] first_byte,
	input wire logic [7:0] second_byte,
	output logic match,
	output logic indexed,
	output logic [5:0] ptr_index
);

	always_comb begin
		// Plain form has bits 7 and 0 clear, indexed form has both set
		match = (first_byte == iwp_pkg::FIRST_BYTE) &&
			(second_byte[iwp_pkg::FORM_BIT] ==
			second_byte[iwp_pkg::TAIL_BIT]);
		indexed = second_byte[iwp_pkg::FORM_BIT];
		// Every index 0..63 is legal
		ptr_index = second_byte[iwp_pkg::IDX_MSB:iwp_pkg::IDX_LSB];
	end

endmodule // iwp_decode

//--- core/iwp_addr.sv
// Source address adder with signed byte displacement
`timescale 1ns/1ps
module iwp_addr (
	input wire logic [15:0] pointer,
	input wire logic indexed,
	input wire logic [7:0] disp,
	output logic [15:0] src_addr
);

	logic [15:0] disp_ext;

	always_comb begin
		// Sign-extend so the reach is -128..+127
		disp_ext = indexed ? {{8{disp[7]}}, disp} : 16'h0000;
		src_addr = pointer + disp_ext;
	end

endmodule // iwp_addr

//--- core/iwp_core.sv
// Execution sequencer for the indirect word push instructions
`timescale 1ns/1ps
module iwp_core (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic [7:0] first_byte,
	input wire logic [7:0] second_byte,
	input wire logic [7:0] disp_reg,
	input wire logic sp_load,
	input wire logic [15:0] sp_load_val,
	input wire logic pc_load,
	input wire logic [15:0] pc_load_val,
	input wire logic status_load,
	input wire logic status_load_val,
	input wire logic [8:0] mem_rdata,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [8:0] mem_wdata,
	output logic [15:0] stack_pointer,
	output logic [15:0] program_counter,
	output logic status_ninth_bit_copy,
	output logic busy,
	output logic done,
	output logic bad_opcode
);

	iwp_pkg::iwp_state_t state_r;
	logic dec_match;
	logic dec_indexed;
	logic [5:0] dec_index;
	logic indexed_r;
	logic [5:0] index_r;
	logic [7:0] disp_r;
	logic [7:0] ptr_lo_r;
	logic [15:0] src_addr;
	logic [15:0] src_addr_r;
	logic [8:0] src_lo_r;
	logic [8:0] src_hi_r;
	logic [15:0] ptr_addr;
	logic [iwp_pkg::DIV_W-1:0] div_r;
	logic cyc_tick;
	logic [1:0] cyc_cnt_r;
	logic [15:0] stack_pointer_r;
	logic [15:0] program_counter_r;
	logic status_ninth_bit_copy_r;
	logic source_high_ninth_bit;
	logic source_low_ninth_bit;

	iwp_decode u_decode (
		.first_byte(first_byte),
		.second_byte(second_byte),
		.match(dec_match),
		.indexed(dec_indexed),
		.ptr_index(dec_index)
	);

	// Pointer low byte is held, high byte is taken straight from memory
	iwp_addr u_addr (
		.pointer({mem_rdata[7:0], ptr_lo_r}),
		.indexed(indexed_r),
		.disp(disp_r),
		.src_addr(src_addr)
	);

	// Each pointer register occupies two bytes at base plus twice the index
	assign ptr_addr = iwp_pkg::PTR_BASE + {9'h000, index_r, 1'b0};
	assign source_high_ninth_bit = src_hi_r[iwp_pkg::NINTH_BIT];
	assign source_low_ninth_bit = src_lo_r[iwp_pkg::NINTH_BIT];

	// Instruction cycle divider, restarted at each accepted push
	assign cyc_tick = (div_r ==
		iwp_pkg::DIV_W'(iwp_pkg::CLKS_PER_CYCLE - 1));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_r <= '0;
		end else if (state_r == iwp_pkg::ST_IDLE || cyc_tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + iwp_pkg::DIV_W'(1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc_cnt_r <= 2'h0;
		end else if (state_r == iwp_pkg::ST_IDLE) begin
			cyc_cnt_r <= 2'h0;
		end else if (cyc_tick && cyc_cnt_r != iwp_pkg::INSTR_CYCLES) begin
			cyc_cnt_r <= cyc_cnt_r + 2'h1;
		end
	end

	// Operand capture at acceptance
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			indexed_r <= 1'b0;
			index_r <= 6'h00;
			disp_r <= 8'h00;
		end else if (state_r == iwp_pkg::ST_IDLE && start && dec_match) begin
			indexed_r <= dec_indexed;
			index_r <= dec_index;
			disp_r <= disp_reg;
		end
	end

	// Sequencer: memory answers one cycle after a read is presented
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= iwp_pkg::ST_IDLE;
		end else begin
			unique case (state_r)
				iwp_pkg::ST_IDLE: begin
					if (start && dec_match) begin
						state_r <= iwp_pkg::ST_PTR_LO;
					end
				end
				iwp_pkg::ST_PTR_LO: state_r <= iwp_pkg::ST_PTR_HI;
				iwp_pkg::ST_PTR_HI: state_r <= iwp_pkg::ST_PTR_GET;
				iwp_pkg::ST_PTR_GET: state_r <= iwp_pkg::ST_SRC_LO;
				iwp_pkg::ST_SRC_LO: state_r <= iwp_pkg::ST_SRC_HI;
				iwp_pkg::ST_SRC_HI: state_r <= iwp_pkg::ST_SRC_GET;
				iwp_pkg::ST_SRC_GET: state_r <= iwp_pkg::ST_WR_LO;
				iwp_pkg::ST_WR_LO: state_r <= iwp_pkg::ST_WR_HI;
				iwp_pkg::ST_WR_HI: state_r <= iwp_pkg::ST_FINISH;
				iwp_pkg::ST_FINISH: begin
					// Hold until the third instruction cycle ends
					if (cyc_tick && cyc_cnt_r ==
						iwp_pkg::INSTR_CYCLES - 2'h1) begin
						state_r <= iwp_pkg::ST_IDLE;
					end
				end
				default: state_r <= iwp_pkg::ST_IDLE;
			endcase
		end
	end

	// Read strobe, one clock per byte read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_rd <= 1'b0;
		end else begin
			mem_rd <= state_r == iwp_pkg::ST_PTR_LO ||
				state_r == iwp_pkg::ST_PTR_HI ||
				state_r == iwp_pkg::ST_SRC_LO ||
				state_r == iwp_pkg::ST_SRC_HI;
		end
	end

	// Write strobe, one clock per stacked byte
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_wr <= 1'b0;
		end else begin
			mem_wr <= state_r == iwp_pkg::ST_WR_LO ||
				state_r == iwp_pkg::ST_WR_HI;
		end
	end

	// Memory address for each access
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_addr <= 16'h0000;
		end else begin
			unique case (state_r)
				iwp_pkg::ST_PTR_LO: mem_addr <= ptr_addr;
				iwp_pkg::ST_PTR_HI: mem_addr <= ptr_addr + 16'h0001;
				iwp_pkg::ST_SRC_LO: mem_addr <= src_addr;
				iwp_pkg::ST_SRC_HI: mem_addr <= src_addr_r + 16'h0001;
				iwp_pkg::ST_WR_LO, iwp_pkg::ST_WR_HI: begin
					// Stack pointer has stepped once before the high byte
					mem_addr <= stack_pointer_r + 16'h0001;
				end
				default: begin
				end
			endcase
		end
	end

	// Write data, low byte first
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_wdata <= 9'h000;
		end else if (state_r == iwp_pkg::ST_WR_LO) begin
			mem_wdata <= src_lo_r;
		end else if (state_r == iwp_pkg::ST_WR_HI) begin
			mem_wdata <= src_hi_r;
		end
	end

	// Pointer low byte
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ptr_lo_r <= 8'h00;
		end else if (state_r == iwp_pkg::ST_PTR_GET) begin
			ptr_lo_r <= mem_rdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src_addr_r <= 16'h0000;
		end else if (state_r == iwp_pkg::ST_SRC_LO) begin
			// Pointer high byte arrives now
			src_addr_r <= src_addr;
		end
	end

	// Source word bytes with their ninth bits
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src_lo_r <= 9'h000;
		end else if (state_r == iwp_pkg::ST_SRC_GET) begin
			src_lo_r <= mem_rdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src_hi_r <= 9'h000;
		end else if (state_r == iwp_pkg::ST_WR_LO) begin
			src_hi_r <= mem_rdata;
		end
	end

	// Stack pointer: one step before each stacked byte
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stack_pointer_r <= iwp_pkg::SP_RESET;
		end else if (state_r == iwp_pkg::ST_WR_LO ||
			state_r == iwp_pkg::ST_WR_HI) begin
			stack_pointer_r <= stack_pointer_r + 16'h0001;
		end else if (sp_load && state_r == iwp_pkg::ST_IDLE) begin
			stack_pointer_r <= sp_load_val;
		end
	end

	// Status copy of the source high ninth bit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_ninth_bit_copy_r <= 1'b0;
		end else if (state_r == iwp_pkg::ST_WR_HI) begin
			status_ninth_bit_copy_r <= source_high_ninth_bit;
		end else if (status_load && state_r == iwp_pkg::ST_IDLE) begin
			status_ninth_bit_copy_r <= status_load_val;
		end
	end

	// Program counter advance at completion
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			program_counter_r <= iwp_pkg::PC_RESET;
		end else if (state_r == iwp_pkg::ST_FINISH && cyc_tick &&
			cyc_cnt_r == iwp_pkg::INSTR_CYCLES - 2'h1) begin
			program_counter_r <= program_counter_r +
				iwp_pkg::INSTR_BYTES;
		end else if (pc_load && state_r == iwp_pkg::ST_IDLE) begin
			program_counter_r <= pc_load_val;
		end
	end

	// Completion pulse at the end of the third instruction cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			done <= 1'b0;
		end else begin
			done <= state_r == iwp_pkg::ST_FINISH && cyc_tick &&
				cyc_cnt_r == iwp_pkg::INSTR_CYCLES - 2'h1;
		end
	end

	// Refusal pulse for unrecognised bytes while idle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bad_opcode <= 1'b0;
		end else begin
			bad_opcode <= state_r == iwp_pkg::ST_IDLE && start &&
				!dec_match;
		end
	end

	// Busy level, low exactly when the sequencer is idle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
		end else if (state_r == iwp_pkg::ST_IDLE) begin
			busy <= start && dec_match;
		end else if (state_r == iwp_pkg::ST_FINISH && cyc_tick &&
			cyc_cnt_r == iwp_pkg::INSTR_CYCLES - 2'h1) begin
			busy <= 1'b0;
		end
	end

	assign stack_pointer = stack_pointer_r;
	assign program_counter = program_counter_r;
	assign status_ninth_bit_copy = status_ninth_bit_copy_r;

endmodule // iwp_core

//--- dv/iwp_core_assertions.sv
// Port-level checker for the indirect word push sequencer
`timescale 1ns/1ps
module iwp_chk (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic [7:0] first_byte,
	input wire logic [7:0] second_byte,
	input wire logic [8:0] mem_rdata,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [8:0] mem_wdata,
	input wire logic [15:0] stack_pointer,
	input wire logic [15:0] program_counter,
	input wire logic status_ninth_bit_copy,
	input wire logic busy,
	input wire logic done,
	input wire logic bad_opcode
);
	logic ok;
	logic acc;
	logic [15:0] ptr_r;
	logic [15:0] sp_r;
	logic [15:0] pc_r;
	assign ok = first_byte == iwp_pkg::FIRST_BYTE &&
		second_byte[7] == second_byte[0];
	assign acc = start && !busy && ok;
	// Snapshot of the accepted request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ptr_r <= 16'h0000;
			sp_r <= 16'h0000;
			pc_r <= 16'h0000;
		end else if (acc) begin
			ptr_r <= iwp_pkg::PTR_BASE + {9'h000, second_byte[6:1], 1'b0};
			sp_r <= stack_pointer;
			pc_r <= program_counter;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_busy; acc |=> busy [*8]; endproperty
	a_busy: assert property (p_busy) else $error("busy dropped");
	property p_done; acc |-> ##13 done && !busy; endproperty
	a_done: assert property (p_done) else $error("done late");
	property p_ptr;
		acc |-> ##2 mem_rd && mem_addr == ptr_r
			##1 mem_rd && mem_addr == ptr_r + 16'h0001;
	endproperty
	a_ptr: assert property (p_ptr) else $error("bad ptr read");
	property p_wr;
		acc |-> ##8 mem_wr && mem_addr == sp_r + 16'h0001
			##1 mem_wr && mem_addr == sp_r + 16'h0002;
	endproperty
	a_wr: assert property (p_wr) else $error("bad stack write");
	property p_sp; acc |-> ##10 stack_pointer == sp_r + 16'h0002; endproperty
	a_sp: assert property (p_sp) else $error("bad stack ptr");
	property p_pc; acc |-> ##13 program_counter == pc_r + 16'h0002; endproperty
	a_pc: assert property (p_pc) else $error("bad program ctr");
	property p_data; mem_wr |-> mem_wdata == $past(mem_rdata, 2); endproperty
	a_data: assert property (p_data) else $error("bad write data");
	property p_stat;
		mem_wr && $past(mem_wr) |=> status_ninth_bit_copy == $past(mem_wdata[8]);
	endproperty
	a_stat: assert property (p_stat) else $error("bad status bit");
	property p_bad; start && !busy && !ok |=> bad_opcode && !busy; endproperty
	a_bad: assert property (p_bad) else $error("not refused");
	c_plain: cover property (acc && !second_byte[7]);
	c_idx: cover property (acc && second_byte[7]);
	c_bad: cover property (bad_opcode);
endmodule // iwp_chk

bind iwp_core iwp_chk u_chk (.clk(clk), .arst_n(arst_n), .start(start),
	.first_byte(first_byte), .second_byte(second_byte),
	.mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
	.mem_wr(mem_wr), .mem_wdata(mem_wdata), .stack_pointer(stack_pointer),
	.program_counter(program_counter), .busy(busy), .done(done),
	.status_ninth_bit_copy(status_ninth_bit_copy), .bad_opcode(bad_opcode));

//--- dv/tb_indirect_word_push.sv
// Self-checking bench for the indirect word push sequencer
`timescale 1ns/1ps
module tb_indirect_word_push;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic start = 1'b0;
	logic [7:0] first_byte = 8'h00;
	logic [7:0] second_byte = 8'h00;
	logic [7:0] disp_reg = 8'h00;
	logic sp_load = 1'b0;
	logic [15:0] sp_load_val = 16'h0000;
	logic pc_load = 1'b0;
	logic [15:0] pc_load_val = 16'h0000;
	logic status_load = 1'b0;
	logic status_load_val = 1'b0;
	logic [8:0] mem_rdata = 9'h000;
	logic mem_rd, mem_wr, busy, done, bad_opcode, status_ninth_bit_copy;
	logic [15:0] mem_addr, stack_pointer, program_counter, a_q;
	logic [8:0] mem_wdata, d_q;
	logic rd_q, wr_q;
	logic [8:0] mem [0:65535];
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	iwp_core dut (.clk(clk), .arst_n(arst_n), .start(start),
		.first_byte(first_byte), .second_byte(second_byte),
		.disp_reg(disp_reg), .sp_load(sp_load), .sp_load_val(sp_load_val),
		.pc_load(pc_load), .pc_load_val(pc_load_val),
		.status_load(status_load), .status_load_val(status_load_val),
		.mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .stack_pointer(stack_pointer),
		.program_counter(program_counter), .busy(busy), .done(done),
		.status_ninth_bit_copy(status_ninth_bit_copy),
		.bad_opcode(bad_opcode));
	always #25 clk = ~clk;
	// Memory answers one clock after a read, otherwise shows junk
	always @(posedge clk) begin
		rd_q = mem_rd;
		wr_q = mem_wr;
		a_q = mem_addr;
		d_q = mem_wdata;
		#1;
		if (wr_q)
			mem[a_q] = d_q;
		mem_rdata = rd_q ? mem[a_q] : ~mem_rdata;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			summarize();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic push(input logic [7:0] sb, input logic [7:0] dsp,
		input logic [15:0] ptr, input logic [8:0] lo, input logic [8:0] hi);
		logic [15:0] pa;
		logic [15:0] src;
		int n;
		pa = {9'h000, sb[6:1], 1'b0};
		src = sb[7] ? ptr + {{8{dsp[7]}}, dsp} : ptr;
		mem[pa] = {1'b0, ptr[7:0]};
		mem[pa + 16'h0001] = {1'b0, ptr[15:8]};
		mem[src] = lo;
		mem[src + 16'h0001] = hi;
		sp_load = 1'b1;
		sp_load_val = 16'h00c7;
		pc_load = 1'b1;
		pc_load_val = 16'h0100;
		status_load = 1'b1;
		status_load_val = ~hi[8];
		@(posedge clk);
		#1;
		sp_load = 1'b0;
		pc_load = 1'b0;
		status_load = 1'b0;
		first_byte = 8'h27;
		second_byte = sb;
		disp_reg = dsp;
		start = 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			if (n == 0)
				start = 1'b0;
			n++;
		end while (done !== 1'b1 && n < 40);
		// The acceptance edge is counted as well
		chk(16'(n), 16'(iwp_pkg::CLKS_PER_CYCLE * 3 + 1));
		chk(program_counter, 16'h0102);
		chk(stack_pointer, 16'h00c9);
		chk(16'(mem[16'h00c8]), 16'(lo));
		chk(16'(mem[16'h00c9]), 16'(hi));
		chk(16'(status_ninth_bit_copy), 16'(hi[8]));
	endtask
	task automatic bad_op(input logic [7:0] fb, input logic [7:0] sb);
		first_byte = fb;
		second_byte = sb;
		start = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		chk(16'(bad_opcode), 16'h0001);
		chk(16'(busy), 16'h0000);
		@(posedge clk);
		#1;
		chk(16'(bad_opcode), 16'h0000);
	endtask
	task automatic t_plain();
		push(8'h02, 8'h00, 16'h0051, 9'h034, 9'h112);
		push(8'h7e, 8'h10, 16'h0500, 9'h1c3, 9'h03c);
	endtask
	task automatic t_indexed();
		push(8'hff, 8'h80, 16'h0300, 9'h1aa, 9'h055);
		push(8'h81, 8'h7f, 16'h0400, 9'h0f0, 9'h10f);
	endtask
	task automatic t_bad();
		bad_op(8'h26, 8'h02);
		bad_op(8'h27, 8'h80);
		bad_op(8'h27, 8'h01);
	endtask
	task automatic summarize();
		$display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1;
		arst_n = 1'b1;
		t_plain();
		t_bad();
		t_indexed();
		summarize();
	end
endmodule // tb_indirect_word_push
